// ==== rtpc_host_model.sv ====
// behavioural host at the far end of the inverted serial link
`timescale 1ns/1ps
`default_nettype none
module rtpc_host_model #(
   parameter int BIT_CYC = 520
) (
   // clock
   input  wire logic       i_clock,
   // serial pins seen from the host
   input  wire logic       i_line_in,
   output logic            o_line_out,
   // received character, stop level above the data
   output logic            o_got,
   output logic [8:0]      o_word
);
   // inverted line idles low
   initial begin
      o_line_out = 1'b0;
      o_got      = 1'b0;
      o_word     = 9'h000;
   end

   // one character, lsb first, every level inverted
   task automatic send(input logic [7:0] b);
      @(negedge i_clock);
      o_line_out = 1'b1;
      repeat (BIT_CYC) @(negedge i_clock);
      for (int i = 0; i < 8; i++) begin
         o_line_out = ~b[i];
         repeat (BIT_CYC) @(negedge i_clock);
      end
      o_line_out = 1'b0;
      repeat (BIT_CYC) @(negedge i_clock);
   endtask

   // receiver samples mid bit; a low stop reads back as 1
   always begin
      @(posedge i_line_in);
      repeat (BIT_CYC / 2) @(posedge i_clock);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CYC) @(posedge i_clock);
         o_word[i] = ~i_line_in;
      end
      repeat (BIT_CYC) @(posedge i_clock);
      o_word[8] = ~i_line_in;
      o_got = 1'b1;
      @(posedge i_clock);
      o_got = 1'b0;
   end
endmodule
`default_nettype wire

// ==== rtpc_params.svh ====
// constants for the resistive touch pin control block
//
// Summary of operation
// - sample clock-select strap once; high means 10 MHz
// - shutdown pin low holds power save
// - shutdown pin beats automatic power save setting
// - automatic power save after idle, configurable
// - indicator low when running, high in save
// - reset input low resets everything
// - serial lines use inverted polarity
// - terminal-ready high is not ready, low ready
// - serial link runs at 38400 baud
// - command A0 toggles external filter path
// - filtered signal feeds conversions when enabled
// - calibration with 2, 5 or 13 points
// - settings kept in non-volatile storage
// - oversampling, delta limit and focus averaging
// - pressure measurement along Z axis
// - eight data bits, no parity, one stop
// - commands have bit 7 set, data clear
`ifndef RTPC_PARAMS_SVH
`define RTPC_PARAMS_SVH

//----------------------------------------------------------------
// timing
//----------------------------------------------------------------
`define RTPC_CLK_HZ      20000000
`define RTPC_BAUD        38400
`define RTPC_BIT_CYC     (`RTPC_CLK_HZ / `RTPC_BAUD)
`define RTPC_HALF_CYC    (`RTPC_BIT_CYC / 2)
`define RTPC_IDLE_MS     1000
`define RTPC_CYC_PER_MS  (`RTPC_CLK_HZ / 1000)

//----------------------------------------------------------------
// command and reply bytes
//----------------------------------------------------------------
`define RTPC_CMD_BIT     7
`define RTPC_CMD_CLKSPD  8'hB0
`define RTPC_CMD_CALNUM  8'hB3
`define RTPC_CMD_FILTER  8'hA0
`define RTPC_CMD_AUTOPS  8'hA2
`define RTPC_CMD_PRESS   8'hA4
`define RTPC_CMD_WAKE    8'hA7
`define RTPC_CMD_SHUT    8'hA8
`define RTPC_REP_ACK     8'hCA
`define RTPC_SPD_3M3     8'h00
`define RTPC_SPD_10M     8'h01
`define RTPC_CAL_2       8'h02
`define RTPC_CAL_5       8'h05
`define RTPC_CAL_13      8'h0D

//----------------------------------------------------------------
// reset values
//----------------------------------------------------------------
`define RTPC_RST_FILTER  1'b0
`define RTPC_RST_AUTOPS  1'b0
`define RTPC_RST_PRESS   1'b0
`define RTPC_AVG_ALL     3'h7

`endif

// ==== rtpc_pkg.sv ====
// types shared by the resistive touch pin control block
package rtpc_pkg;
   typedef enum logic [1:0] {U_IDLE, U_START, U_DATA, U_STOP} rtpc_uart_st_t;
   typedef enum logic {PS_RUN, PS_SAVE} rtpc_ps_st_t;
   typedef struct packed {
      logic filter_en;
      logic auto_ps_en;
      logic press_en;
   } rtpc_settings_t;
endpackage

// ==== rtpc_top.sv ====
// resistive touch controller pin control and power save logic
`timescale 1ns/1ps
`default_nettype none
`include "rtpc_params.svh"
module rtpc_top #(
   parameter int IDLE_CYC = `RTPC_IDLE_MS * `RTPC_CYC_PER_MS
) (
   // clock and reset
   input  wire logic       i_clock,
   input  wire logic       i_rst_n,
   // board pins
   input  wire logic       i_clk_set_strap,
   input  wire logic       i_shutdown_n,
   input  wire logic       i_wake_up,
   input  wire logic       i_uart_rx,
   input  wire logic       i_dtr_n,
   output logic            o_uart_tx,
   output logic            o_power_state_indicator,
   output logic            o_watchdog_output,
   // converter side
   input  wire logic       i_touch_detect,
   input  wire logic [1:0] i_cal_points_sel,
   output logic            o_clk_sel_10mhz,
   output logic            o_sampling_en,
   output logic            o_filter_path_en,
   output logic            o_conv_from_filter,
   output logic            o_pressure_en,
   output logic            o_auto_ps_en,
   output logic [2:0]      o_avg_methods,
   output logic            o_nv_store
);
   localparam logic [24:0] IDLE_LAST = 25'(IDLE_CYC - 1);

   logic       strap_s1_q, strap_s2_q, shut_s1_q, shut_s2_q;
   logic       wake_s1_q, wake_s2_q, dtr_s1_q, dtr_s2_q;
   logic [1:0] strap_cnt_q, strap_cnt_d;
   logic       clk10_q, clk10_d, strap_done;
   rtpc_pkg::rtpc_ps_st_t  ps_q, ps_d;
   rtpc_pkg::rtpc_settings_t set_q, set_d;
   logic [24:0] idle_q, idle_d;
   logic        idle_done, shut_lo;
   logic        rx_valid, tx_busy, tx_start_q, tx_start_d;
   logic [7:0]  rx_data, tx_byte_q, tx_byte_d;
   logic [1:0]  rep_cnt_q, rep_cnt_d;
   logic [7:0]  rep0_q, rep0_d, rep1_q, rep1_d;
   logic        nv_q, nv_d, cmd_ok, ind_q, samp_q, filt_q, wdog_q;

   // true when a received byte is a command byte
   function automatic logic is_cmd(input logic [7:0] b);
      return b[`RTPC_CMD_BIT];
   endfunction

   function automatic logic [7:0] cal_code(input logic [1:0] s);
      case (s)
         2'h0:    return `RTPC_CAL_2;
         2'h1:    return `RTPC_CAL_5;
         default: return `RTPC_CAL_13;
      endcase
   endfunction

   //----------------------------------------------------------------
   // pin synchronisers
   //----------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         strap_s1_q <= 1'b1;
         strap_s2_q <= 1'b1;
         shut_s1_q  <= 1'b1;
         shut_s2_q  <= 1'b1;
         wake_s1_q  <= 1'b1;
         wake_s2_q  <= 1'b1;
         dtr_s1_q   <= 1'b1;
         dtr_s2_q   <= 1'b1;
      end else begin
         strap_s1_q <= i_clk_set_strap;
         strap_s2_q <= strap_s1_q;
         shut_s1_q  <= i_shutdown_n;
         shut_s2_q  <= shut_s1_q;
         wake_s1_q  <= i_wake_up;
         wake_s2_q  <= wake_s1_q;
         dtr_s1_q   <= i_dtr_n;
         dtr_s2_q   <= dtr_s1_q;
      end
   end

   assign shut_lo   = ~shut_s2_q;
   assign idle_done = (idle_q == IDLE_LAST);
   assign cmd_ok    = rx_valid && is_cmd(rx_data) && (rep_cnt_q == 2'h0);

   //----------------------------------------------------------------
   // clock strap: caught once, after the synchroniser has filled
   //----------------------------------------------------------------
   assign strap_done = (strap_cnt_q == 2'h3);
   always_comb begin
      strap_cnt_d = strap_cnt_q;
      clk10_d     = clk10_q;
      if (!strap_done) begin
         strap_cnt_d = strap_cnt_q + 2'h1;
         if (strap_cnt_q == 2'h2) begin
            clk10_d = strap_s2_q;
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         strap_cnt_q <= 2'h0;
         clk10_q     <= 1'b1;
      end else begin
         strap_cnt_q <= strap_cnt_d;
         clk10_q     <= clk10_d;
      end
   end

   //----------------------------------------------------------------
   // power save state and idle timer
   //----------------------------------------------------------------
   always_comb begin
      ps_d   = ps_q;
      idle_d = idle_q;
      case (ps_q)
         rtpc_pkg::PS_RUN: begin
            if (i_touch_detect || rx_valid) begin
               idle_d = 25'h0000000;
            end else if (!idle_done) begin
               idle_d = idle_q + 25'h0000001;
            end
            if (shut_lo) begin
               ps_d = rtpc_pkg::PS_SAVE;
            end else if (set_q.auto_ps_en && idle_done) begin
               ps_d = rtpc_pkg::PS_SAVE;
            end else if (cmd_ok && rx_data == `RTPC_CMD_SHUT) begin
               ps_d = rtpc_pkg::PS_SAVE;
            end
         end
         rtpc_pkg::PS_SAVE: begin
            idle_d = 25'h0000000;
            // wake line is pulled low by a touch on the panel line
            if (!shut_lo && (!wake_s2_q || rx_valid)) begin
               ps_d = rtpc_pkg::PS_RUN;
            end
         end
         default: ps_d = rtpc_pkg::PS_RUN;
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         ps_q   <= rtpc_pkg::PS_RUN;
         idle_q <= 25'h0000000;
      end else begin
         ps_q   <= ps_d;
         idle_q <= idle_d;
      end
   end

   //----------------------------------------------------------------
   // command decode, settings and reply queue
   //----------------------------------------------------------------
   always_comb begin
      set_d      = set_q;
      rep_cnt_d  = rep_cnt_q;
      rep0_d     = rep0_q;
      rep1_d     = rep1_q;
      nv_d       = 1'b0;
      tx_start_d = 1'b0;
      tx_byte_d  = tx_byte_q;
      if (cmd_ok) begin
         rep0_d    = `RTPC_REP_ACK;
         rep_cnt_d = 2'h1;
         case (rx_data)
            `RTPC_CMD_FILTER: begin
               set_d.filter_en = ~set_q.filter_en;
               rep1_d    = {7'h00, ~set_q.filter_en};
               rep_cnt_d = 2'h2;
               nv_d      = 1'b1;
            end
            `RTPC_CMD_AUTOPS: begin
               set_d.auto_ps_en = ~set_q.auto_ps_en;
               rep1_d    = {7'h00, ~set_q.auto_ps_en};
               rep_cnt_d = 2'h2;
               nv_d      = 1'b1;
            end
            `RTPC_CMD_PRESS: begin
               set_d.press_en = ~set_q.press_en;
               rep1_d    = {7'h00, ~set_q.press_en};
               rep_cnt_d = 2'h2;
               nv_d      = 1'b1;
            end
            `RTPC_CMD_CLKSPD: begin
               rep1_d    = clk10_q ? `RTPC_SPD_10M : `RTPC_SPD_3M3;
               rep_cnt_d = 2'h2;
            end
            `RTPC_CMD_CALNUM: begin
               rep1_d    = cal_code(i_cal_points_sel);
               rep_cnt_d = 2'h2;
            end
            `RTPC_CMD_WAKE: rep_cnt_d = 2'h0; // wake gets no reply
            default: rep_cnt_d = 2'h1;
         endcase
      end else if (rep_cnt_q != 2'h0 && !tx_busy && !tx_start_q
                   && !dtr_s2_q) begin
         // hold replies while the host reports not ready
         tx_start_d = 1'b1;
         tx_byte_d  = rep0_q;
         rep0_d     = rep1_q;
         rep_cnt_d  = rep_cnt_q - 2'h1;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         set_q      <= '{`RTPC_RST_FILTER, `RTPC_RST_AUTOPS,
                         `RTPC_RST_PRESS};
         rep_cnt_q  <= 2'h0;
         rep0_q     <= 8'h00;
         rep1_q     <= 8'h00;
         nv_q       <= 1'b0;
         tx_start_q <= 1'b0;
         tx_byte_q  <= 8'h00;
      end else begin
         set_q      <= set_d;
         rep_cnt_q  <= rep_cnt_d;
         rep0_q     <= rep0_d;
         rep1_q     <= rep1_d;
         nv_q       <= nv_d;
         tx_start_q <= tx_start_d;
         tx_byte_q  <= tx_byte_d;
      end
   end

   //----------------------------------------------------------------
   // output flops; indicator, sampling and filter follow the next-state values
   //----------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         ind_q  <= 1'b0;
         samp_q <= 1'b1;
         filt_q <= `RTPC_RST_FILTER;
         wdog_q <= 1'b0;
      end else begin
         wdog_q <= 1'b1;
         ind_q  <= (ps_d == rtpc_pkg::PS_SAVE);
         samp_q <= (ps_d == rtpc_pkg::PS_RUN);
         filt_q <= set_d.filter_en;
      end
   end

   assign o_power_state_indicator = ind_q;
   assign o_sampling_en           = samp_q;
   assign o_filter_path_en        = filt_q;
   assign o_conv_from_filter      = filt_q;
   assign o_pressure_en           = set_q.press_en;
   assign o_auto_ps_en            = set_q.auto_ps_en;
   assign o_clk_sel_10mhz         = clk10_q;
   assign o_avg_methods           = `RTPC_AVG_ALL;
   assign o_nv_store              = nv_q;
   // no watchdog source here; line rests high so it never resets
   assign o_watchdog_output       = wdog_q;

   rtpc_uart u_uart (
      .i_clock    (i_clock),
      .i_rst_n    (i_rst_n),
      .i_rx_pin   (i_uart_rx),
      .o_tx_pin   (o_uart_tx),
      .i_tx_start (tx_start_q),
      .i_tx_data  (tx_byte_q),
      .o_tx_busy  (tx_busy),
      .o_rx_valid (rx_valid),
      .o_rx_data  (rx_data)
   );

   //----------------------------------------------------------------
   // checks
   //----------------------------------------------------------------
   AST_STRAP_ONCE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      strap_done && $past(strap_done) |-> $stable(o_clk_sel_10mhz))
      else $error("clock select changed after strap capture");
   AST_SHUT_SAVE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      shut_lo |=> o_power_state_indicator)
      else $error("shutdown low did not give power save");
   AST_SHUT_HOLD: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      shut_lo && ps_q == rtpc_pkg::PS_SAVE && rx_valid
      |=> ps_q == rtpc_pkg::PS_SAVE)
      else $error("left power save while shutdown held low");
   AST_AUTO_SAVE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      ps_q == rtpc_pkg::PS_RUN && set_q.auto_ps_en && idle_done
      |=> ps_q == rtpc_pkg::PS_SAVE ##0 o_power_state_indicator)
      else $error("automatic power save not entered");
   AST_IND_STATE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      o_power_state_indicator == (ps_q == rtpc_pkg::PS_SAVE)
      && o_sampling_en == !o_power_state_indicator)
      else $error("indicator does not match power state");
   AST_RESET_RUN: assert property (@(posedge i_clock)
      !i_rst_n |=> !o_power_state_indicator && rep_cnt_q == 2'h0)
      else $error("reset did not restore normal operation");
   AST_DTR_HOLD: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      tx_start_q |-> !$past(dtr_s2_q))
      else $error("byte sent while host not ready");
   AST_FILTER_TOGGLE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      cmd_ok && rx_data == `RTPC_CMD_FILTER
      |=> o_filter_path_en != $past(o_filter_path_en) ##0 rep_cnt_q == 2'h2)
      else $error("filter command did not toggle path");
   AST_DATA_IGNORED: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      rx_valid && !rx_data[7] && rep_cnt_q == 2'h0 |=> rep_cnt_q == 2'h0)
      else $error("data byte treated as command");
   AST_WAKE_RESUME: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      $fell(o_power_state_indicator) |-> o_sampling_en)
      else $error("sampling not resumed on wake");
endmodule
`default_nettype wire

// ==== rtpc_top_test.sv ====
// self-checking bench for the pin control and power save block
`timescale 1ns/1ps
`default_nettype none
`include "rtpc_params.svh"
module rtpc_top_test;
   logic       i_clock, i_rst_n, strap, shut_n, wake, dtr_n, touch, rx;
   logic       tx, power_state_indicator, wdog, clk10, samp, filt, conv, press, autops, nv;
   logic       got;
   logic [1:0] cal_sel;
   logic [2:0] avg;
   logic [8:0] word;
   logic [8:0] exp_q[$];
   int         err_total, n_checks, nv_cnt;

   rtpc_top #(.IDLE_CYC(50)) dut_u (
      .i_clock(i_clock), .i_rst_n(i_rst_n), .i_clk_set_strap(strap),
      .i_shutdown_n(shut_n), .i_wake_up(wake), .i_uart_rx(rx),
      .i_dtr_n(dtr_n), .o_uart_tx(tx), .o_power_state_indicator(power_state_indicator),
      .o_watchdog_output(wdog), .i_touch_detect(touch),
      .i_cal_points_sel(cal_sel), .o_clk_sel_10mhz(clk10),
      .o_sampling_en(samp), .o_filter_path_en(filt),
      .o_conv_from_filter(conv), .o_pressure_en(press),
      .o_auto_ps_en(autops), .o_avg_methods(avg), .o_nv_store(nv));

   rtpc_host_model host_u (
      .i_clock(i_clock), .i_line_in(tx), .o_line_out(rx),
      .o_got(got), .o_word(word));

   //----------------------------------------------------------------
   // shared tasks
   //----------------------------------------------------------------
   task automatic check(input string what, input logic [8:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic stop_test;
      if (err_total == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // note acknowledge and optional value, then send the command
   task automatic cmd(input logic [7:0] c, v, input bit two);
      exp_q.push_back({1'b1, `RTPC_REP_ACK});
      if (two) exp_q.push_back({1'b1, v});
      host_u.send(c);
   endtask

   // bounded wait for every noted reply, then let the stop bit end
   task automatic drain;
      for (int k = 0; k < 20000 && exp_q.size() > 0; k++)
         @(negedge i_clock);
      check("replies", 9'(exp_q.size()), 9'h000);
      repeat (300) @(negedge i_clock);
   endtask

   // wake line pulled low as a touch on the panel would
   task automatic wake_pulse;
      wake = 1'b0;
      repeat (6) @(negedge i_clock);
      wake = 1'b1;
   endtask

   //----------------------------------------------------------------
   // clock, monitor, watchdog
   //----------------------------------------------------------------
   initial begin
      i_clock = 1'b0;
      forever #25 i_clock = ~i_clock;
   end

   // an unnoted reply pops nothing and compares against zero
   always @(posedge got)
      check("reply", word, exp_q.size() ? exp_q.pop_front() : 9'h000);

   always @(posedge i_clock)
      if (nv === 1'b1) nv_cnt++;

   // run needs about 80k cycles; hang guard kept under the 100k budget
   initial begin
      repeat (95000) @(posedge i_clock);
      err_total++;
      stop_test;
   end

   //----------------------------------------------------------------
   // main sequence
   //----------------------------------------------------------------
   initial begin
      i_rst_n = 1'b0;
      strap   = 1'b1;
      shut_n  = 1'b1;
      wake    = 1'b1;
      dtr_n   = 1'b0;
      touch   = 1'b1;
      cal_sel = 2'h0;
      void'($urandom(61769));
      repeat (6) @(negedge i_clock);
      i_rst_n = 1'b1;
      repeat (5) @(negedge i_clock);
      check("clk_sel", clk10, 1'b1);
      check("avg", avg, `RTPC_AVG_ALL);
      strap = 1'b0;
      cmd(`RTPC_CMD_FILTER, 8'h01, 1'b1);
      drain;
      check("filter", filt, 1'b1);
      check("conv", conv, 1'b1);
      cal_sel = 2'($urandom);
      cmd(`RTPC_CMD_CALNUM, cal_sel == 2'h0 ? `RTPC_CAL_2 :
          cal_sel == 2'h1 ? `RTPC_CAL_5 : `RTPC_CAL_13, 1'b1);
      drain;
      // not ready holds the reply; late strap change is ignored
      dtr_n = 1'b1;
      cmd(`RTPC_CMD_CLKSPD, `RTPC_SPD_10M, 1'b1);
      repeat (2000) @(negedge i_clock);
      check("tx_held", tx, 1'b0);
      dtr_n = 1'b0;
      drain;
      // data byte alone draws no reply, seen by the monitor
      host_u.send(8'($urandom) & 8'h7F);
      repeat (600) @(negedge i_clock);
      cmd(`RTPC_CMD_SHUT, 8'h00, 1'b0);
      drain;
      check("led_save", power_state_indicator, 1'b1);
      check("samp_save", samp, 1'b0);
      wake_pulse;
      check("led_run", power_state_indicator, 1'b0);
      check("samp_run", samp, 1'b1);
      cmd(`RTPC_CMD_AUTOPS, 8'h01, 1'b1);
      drain;
      touch = 1'b0;
      repeat (60) @(negedge i_clock);
      check("led_auto", power_state_indicator, 1'b1);
      touch = 1'b1;
      wake_pulse;
      check("led_woke", power_state_indicator, 1'b0);
      // pin low wins while touch keeps the idle timer clear
      shut_n = 1'b0;
      repeat (6) @(negedge i_clock);
      check("led_pin", power_state_indicator, 1'b1);
      shut_n = 1'b1;
      wake_pulse;
      check("led_back", power_state_indicator, 1'b0);
      check("nv", 9'(nv_cnt), 9'h002);
      i_rst_n = 1'b0;
      repeat (2) @(negedge i_clock);
      check("wdog", wdog, 1'b0);
      check("filt_rst", filt, 1'b0);
      check("auto_rst", autops, 1'b0);
      i_rst_n = 1'b1;
      stop_test;
   end
endmodule
`default_nettype wire

// ==== rtpc_uart.sv ====
// inverted-polarity 8n1 serial transmitter and receiver
`timescale 1ns/1ps
`default_nettype none
`include "rtpc_params.svh"
module rtpc_uart (
   // clock and reset
   input  wire logic       i_clock,
   input  wire logic       i_rst_n,
   // pins
   input  wire logic       i_rx_pin,
   output logic            o_tx_pin,
   // user side
   input  wire logic       i_tx_start,
   input  wire logic [7:0] i_tx_data,
   output logic            o_tx_busy,
   output logic            o_rx_valid,
   output logic [7:0]      o_rx_data
);
   localparam logic [9:0] BIT_M1  = 10'(`RTPC_BIT_CYC - 1);
   localparam logic [9:0] HALF_M1 = 10'(`RTPC_HALF_CYC - 1);

   logic rx_s1_q, rx_s2_q;
   rtpc_pkg::rtpc_uart_st_t rst_q, rst_d, tst_q, tst_d;
   logic [9:0] rcnt_q, rcnt_d, tcnt_q, tcnt_d;
   logic [2:0] rbit_q, rbit_d, tbit_q, tbit_d;
   logic [7:0] rsh_q, rsh_d, tsh_q, tsh_d;
   logic       rval_q, rval_d, tpin_q, tpin_d;
   logic       rx_line;

   // pin is inverted: idle line sits low, start bit is high
   assign rx_line = ~rx_s2_q;

   //----------------------------------------------------------------
   // receiver, 8 data bits and one stop, no parity
   //----------------------------------------------------------------
   always_comb begin
      rst_d  = rst_q;
      rcnt_d = rcnt_q;
      rbit_d = rbit_q;
      rsh_d  = rsh_q;
      rval_d = 1'b0;
      case (rst_q)
         rtpc_pkg::U_IDLE: begin
            if (!rx_line) begin
               rst_d  = rtpc_pkg::U_START;
               rcnt_d = HALF_M1; // sample at mid-bit
            end
         end
         rtpc_pkg::U_START: begin
            if (rcnt_q != 10'h000) begin
               rcnt_d = rcnt_q - 10'h001;
            end else if (!rx_line) begin
               rst_d  = rtpc_pkg::U_DATA;
               rcnt_d = BIT_M1;
               rbit_d = 3'h0;
            end else begin
               rst_d = rtpc_pkg::U_IDLE; // glitch, not a start bit
            end
         end
         rtpc_pkg::U_DATA: begin
            if (rcnt_q != 10'h000) begin
               rcnt_d = rcnt_q - 10'h001;
            end else begin
               rsh_d  = {rx_line, rsh_q[7:1]};
               rcnt_d = BIT_M1;
               rbit_d = rbit_q + 3'h1;
               if (rbit_q == 3'h7) begin
                  rst_d = rtpc_pkg::U_STOP;
               end
            end
         end
         rtpc_pkg::U_STOP: begin
            if (rcnt_q != 10'h000) begin
               rcnt_d = rcnt_q - 10'h001;
            end else begin
               rst_d  = rtpc_pkg::U_IDLE;
               rval_d = rx_line; // bad stop bit drops the byte
            end
         end
         default: rst_d = rtpc_pkg::U_IDLE;
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         rx_s1_q <= 1'b0;
         rx_s2_q <= 1'b0;
         rst_q   <= rtpc_pkg::U_IDLE;
         rcnt_q  <= 10'h000;
         rbit_q  <= 3'h0;
         rsh_q   <= 8'h00;
         rval_q  <= 1'b0;
      end else begin
         rx_s1_q <= i_rx_pin;
         rx_s2_q <= rx_s1_q;
         rst_q   <= rst_d;
         rcnt_q  <= rcnt_d;
         rbit_q  <= rbit_d;
         rsh_q   <= rsh_d;
         rval_q  <= rval_d;
      end
   end

   //----------------------------------------------------------------
   // transmitter
   //----------------------------------------------------------------
   always_comb begin
      tst_d  = tst_q;
      tcnt_d = tcnt_q;
      tbit_d = tbit_q;
      tsh_d  = tsh_q;
      tpin_d = 1'b0;
      case (tst_q)
         rtpc_pkg::U_IDLE: begin
            if (i_tx_start) begin
               tst_d  = rtpc_pkg::U_START;
               tsh_d  = i_tx_data;
               tcnt_d = BIT_M1;
               tpin_d = 1'b1; // start bit, inverted
            end
         end
         rtpc_pkg::U_START, rtpc_pkg::U_DATA: begin
            tpin_d = tpin_q;
            if (tcnt_q != 10'h000) begin
               tcnt_d = tcnt_q - 10'h001;
            end else begin
               tcnt_d = BIT_M1;
               tpin_d = ~tsh_q[0];
               tsh_d  = {1'b0, tsh_q[7:1]};
               if (tst_q == rtpc_pkg::U_START) begin
                  tst_d  = rtpc_pkg::U_DATA;
                  tbit_d = 3'h0;
               end else if (tbit_q == 3'h7) begin
                  tst_d  = rtpc_pkg::U_STOP;
                  tpin_d = 1'b0; // stop bit, inverted
               end else begin
                  tbit_d = tbit_q + 3'h1;
               end
            end
         end
         rtpc_pkg::U_STOP: begin
            if (tcnt_q != 10'h000) begin
               tcnt_d = tcnt_q - 10'h001;
            end else begin
               tst_d = rtpc_pkg::U_IDLE;
            end
         end
         default: tst_d = rtpc_pkg::U_IDLE;
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         tst_q  <= rtpc_pkg::U_IDLE;
         tcnt_q <= 10'h000;
         tbit_q <= 3'h0;
         tsh_q  <= 8'h00;
         tpin_q <= 1'b0;
      end else begin
         tst_q  <= tst_d;
         tcnt_q <= tcnt_d;
         tbit_q <= tbit_d;
         tsh_q  <= tsh_d;
         tpin_q <= tpin_d;
      end
   end

   assign o_tx_pin   = tpin_q;
   assign o_tx_busy  = (tst_q != rtpc_pkg::U_IDLE);
   assign o_rx_valid = rval_q;
   assign o_rx_data  = rsh_q;

   // idle inverted line rests low
   AST_TX_IDLE_LOW: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (tst_q == rtpc_pkg::U_IDLE) && $past(tst_q == rtpc_pkg::U_IDLE)
      |-> !o_tx_pin)
      else $error("inverted tx line not low while idle");
endmodule
`default_nettype wire
